// File: src/bts_pkg.sv
package bts_pkg;

  // ---------------------------------------------------------------
  // Widths and scaling
  // ---------------------------------------------------------------
  localparam int          BTS_PHASE_W    = 32;
  localparam int          BTS_SAMPLE_W   = 16;
  localparam int          BTS_COUNT_W    = 16;
  localparam int          BTS_LAT_W      = 24;
  localparam int          BTS_PER_W      = 24;
  localparam logic [23:0] BTS_FULL_SCALE = 24'h007FFF;
  localparam logic [23:0] BTS_PCT_DIV    = 24'h000064;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] BTS_PHASE_RST  = 32'h00000000;
  localparam logic [15:0] BTS_SAMPLE_RST = 16'h0000;
  localparam logic [15:0] BTS_COUNT_RST  = 16'h0000;
  localparam logic [23:0] BTS_LAT_RST    = 24'h000000;
  localparam logic [23:0] BTS_PER_RST    = 24'h000000;
  localparam logic        BTS_SYNC_RST   = 1'b1;

  // ---------------------------------------------------------------
  // Modes and states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    BTS_IDLE  = 2'h0,
    BTS_DELAY = 2'h1,
    BTS_RUN   = 2'h3,
    BTS_SPACE = 2'h2
  } bts_state_e;

  typedef enum logic [1:0] {
    BTS_KIND_AUTO = 2'h0,
    BTS_KIND_TRIG = 2'h1,
    BTS_KIND_GATE = 2'h2
  } bts_kind_e;

  typedef enum logic [1:0] {
    BTS_POL_OFF  = 2'h0,
    BTS_POL_RISE = 2'h1,
    BTS_POL_FALL = 2'h2
  } bts_pol_e;

  localparam logic BTS_SYNC_PHASE    = 1'b0;
  localparam logic BTS_SYNC_ACTIVITY = 1'b1;
  localparam logic BTS_STOP_CYCLE    = 1'b0;
  localparam logic BTS_STOP_HALF     = 1'b1;

endpackage : bts_pkg

// File: src/bts_trig_if.sv
`timescale 1ns/100ps
`default_nettype none
// Trigger events and gate level from the source stage to the sequencer
interface bts_trig_if;
  logic trig_delayed;
  logic trig_now;
  logic gate_level;
  modport src (output trig_delayed, output trig_now, output gate_level);
  modport seq (input trig_delayed, input trig_now, input gate_level);
endinterface : bts_trig_if
`default_nettype wire

// File: src/bts_trig_src.sv
`timescale 1ns/100ps
`default_nettype none
module bts_trig_src
  import bts_pkg::*;
#(
  parameter int PER_W = BTS_PER_W
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Source selection
  input  wire logic             trig_src_ext,
  input  wire logic [1:0]       ext_polarity,
  input  wire logic [PER_W-1:0] int_period,
  input  wire logic             chan_display_active,
  // Raw trigger inputs
  input  wire logic             ext_trig_in,
  input  wire logic             manual_trigger_key,
  input  wire logic             remote_trig,
  // To the sequencer
  bts_trig_if.src               trig
);

  initial begin
    if (PER_W < 2 || PER_W > 32) $error("bts_trig_src: PER_W out of range");
  end

  typedef struct packed {
    logic [PER_W-1:0] per_cnt;
    logic             int_sq;
    logic             ext_prev;
    logic             key_prev;
    logic             trig_delayed;
    logic             trig_now;
    logic             gate_level;
  } bts_src_s;

  bts_src_s src_reg;
  bts_src_s src_next;

  // ---------------------------------------------------------------
  // Trigger detection
  // ---------------------------------------------------------------
  // Key only counts for the channel whose display is active
  always_comb begin
    logic int_tick;
    logic ext_edge;
    logic ext_lvl;
    logic key_lvl;
    int_tick = 1'b0;
    ext_edge = 1'b0;
    ext_lvl  = 1'b0;
    key_lvl  = manual_trigger_key & chan_display_active;
    src_next = src_reg;
    src_next.ext_prev = ext_trig_in;
    src_next.key_prev = key_lvl;
    // Internal periodic source; a period of zero stops it
    if (int_period == '0) begin
      src_next.per_cnt = '0;
    end else if (src_reg.per_cnt >= int_period - 1'b1) begin
      src_next.per_cnt = '0;
      int_tick = 1'b1;
      src_next.int_sq = ~src_reg.int_sq;
    end else begin
      src_next.per_cnt = src_reg.per_cnt + 1'b1;
    end
    // Polarity off masks the pin, so noise cannot fire
    unique case (ext_polarity)
      BTS_POL_RISE: begin
        ext_edge = ext_trig_in & ~src_reg.ext_prev;
        ext_lvl  = ext_trig_in;
      end
      BTS_POL_FALL: begin
        ext_edge = ~ext_trig_in & src_reg.ext_prev;
        ext_lvl  = ~ext_trig_in;
      end
      default: begin
        ext_edge = 1'b0;
        ext_lvl  = 1'b0;
      end
    endcase
    src_next.trig_delayed = trig_src_ext ? ext_edge : int_tick;
    // Manual and remote triggers bypass the source choice
    src_next.trig_now   = (key_lvl & ~src_reg.key_prev) | remote_trig;
    src_next.gate_level = (trig_src_ext ? ext_lvl : src_reg.int_sq)
                          | key_lvl | remote_trig;
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      src_reg <= '0;
    end else begin
      src_reg <= src_next;
    end
  end

  assign trig.trig_delayed = src_reg.trig_delayed;
  assign trig.trig_now     = src_reg.trig_now;
  assign trig.gate_level   = src_reg.gate_level;

endmodule : bts_trig_src
`default_nettype wire

// File: src/bts_sequencer.sv
// Contract
// - Auto burst repeats mark half-cycles then space half-cycles, no trigger.
// - Auto burst has no halt; it runs while auto stays selected and the waveform is not noise or DC.
// - Continuous mode bypasses bursts and oscillates without pause.
// - Sync select picks phase sync or burst activity for the sync pin.
// - Phase sync rises each time the waveform passes reference phase.
// - Burst activity sync is low while oscillating, high while stopped.
// - Idle level is start/stop sample, or percent of full scale if overridden.
// - With override on, bursts still start at start/stop phase and stop on its half-cycle boundaries.
// - Square with 0 percent override gives three levels, else two.
// - Each burst begins at the start/stop phase and ends on it or half a cycle past it.
// - Each accepted trigger runs exactly the mark count, then idles.
// - Burst count resolution is half a waveform cycle.
// - Triggers are ignored until the whole mark count has run.
// - Internal source has a period; external has selectable polarity.
// - Manual key and remote triggers are accepted whichever trigger source is selected.
// - Internal or external triggers wait the trigger latency.
// - Manual and remote triggers skip the latency.
// - Trigger seen indicator lights on a trigger in trigger burst.
// - Trigger burst is refused for noise or DC waveforms.
// - Manual key acts only on the channel whose display is active.
// - Gate oscillation runs while gate on, ending in whole or half cycles.
`timescale 1ns/100ps
`default_nettype none
module bts_sequencer
  import bts_pkg::*;
#(
  parameter int CNT_W = BTS_COUNT_W,
  parameter int LAT_W = BTS_LAT_W,
  parameter int PER_W = BTS_PER_W
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Oscillation setup
  input  wire logic                    osc_continuous,
  input  wire logic [1:0]              burst_kind_select,
  input  wire logic [BTS_PHASE_W-1:0]  freq_word,
  input  wire logic [BTS_PHASE_W-1:0]  start_phase,
  input  wire logic [CNT_W-1:0]        mark_halves,
  input  wire logic [CNT_W-1:0]        space_halves,
  input  wire logic                    stop_unit_half,
  input  wire logic                    wave_is_noise_dc,
  // Idle level and sync
  input  wire logic                    idle_level_override,
  input  wire logic signed [7:0]       idle_level_pct,
  input  wire logic                    sync_output_select,
  // Trigger setup and inputs
  input  wire logic                    trig_src_ext,
  input  wire logic [1:0]              ext_polarity,
  input  wire logic [PER_W-1:0]        int_period,
  input  wire logic [LAT_W-1:0]        trigger_latency,
  input  wire logic                    chan_display_active,
  input  wire logic                    ext_trig_in,
  input  wire logic                    manual_trigger_key,
  input  wire logic                    remote_trig,
  // Waveform sample at the current phase
  input  wire logic [BTS_SAMPLE_W-1:0] wave_sample,
  // Outputs
  output logic [BTS_PHASE_W-1:0]       phase_out,
  output logic [BTS_SAMPLE_W-1:0]      level_out,
  output logic                         sync_out,
  output logic                         osc_active,
  output logic                         trig_seen
);

  initial begin
    if (CNT_W < 2 || CNT_W > 32) $error("bts_sequencer: CNT_W bad");
    if (LAT_W < 1 || LAT_W > 32) $error("bts_sequencer: LAT_W bad");
  end

  // ---------------------------------------------------------------
  // Trigger source stage
  // ---------------------------------------------------------------
  bts_trig_if trig_bus ();

  bts_trig_src #(
    .PER_W (PER_W)
  ) u_trig_src (
    .clk                 (clk),
    .rst                 (rst),
    .trig_src_ext        (trig_src_ext),
    .ext_polarity        (ext_polarity),
    .int_period          (int_period),
    .chan_display_active (chan_display_active),
    .ext_trig_in         (ext_trig_in),
    .manual_trigger_key  (manual_trigger_key),
    .remote_trig         (remote_trig),
    .trig                (trig_bus.src)
  );

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    bts_state_e              state;
    logic [BTS_PHASE_W-1:0]  phase;
    logic [CNT_W-1:0]        half_cnt;
    logic [LAT_W-1:0]        lat_cnt;
    logic [BTS_SAMPLE_W-1:0] idle_hold;
    logic [BTS_SAMPLE_W-1:0] level;
    logic                    sync;
    logic                    active;
    logic                    seen;
  } bts_seq_s;

  bts_seq_s seq_reg;
  bts_seq_s seq_next;

  // Idle override level: percent of full scale, signed
  logic signed [23:0] pct_product;
  logic signed [23:0] pct_level_full;
  logic [BTS_SAMPLE_W-1:0] pct_level;
  logic refused;
  logic [BTS_PHASE_W-1:0] phase_adv;
  logic [BTS_PHASE_W-1:0] rel_now;
  logic [BTS_PHASE_W-1:0] rel_adv;
  logic half_cross;
  logic full_cross;

  // Percent scaling; a constant divide keeps the path combinational
  assign pct_product    = 24'(idle_level_pct) * signed'(BTS_FULL_SCALE);
  assign pct_level_full = pct_product / signed'(BTS_PCT_DIV);
  assign pct_level      = pct_level_full[BTS_SAMPLE_W-1:0];

  // Noise and DC carry no phase, so triggered and auto bursts cannot start on them
  assign refused = wave_is_noise_dc;

  // Phase relative to start/stop phase; MSB flips every half cycle
  assign phase_adv  = seq_reg.phase + freq_word;
  assign rel_now    = seq_reg.phase - start_phase;
  assign rel_adv    = phase_adv - start_phase;
  assign half_cross = rel_now[BTS_PHASE_W-1] ^ rel_adv[BTS_PHASE_W-1];
  assign full_cross = half_cross & ~rel_adv[BTS_PHASE_W-1];

  // ---------------------------------------------------------------
  // Sequencing
  // ---------------------------------------------------------------
  always_comb begin
    logic start;
    logic [CNT_W-1:0] cnt_inc;
    start    = 1'b0;
    cnt_inc  = seq_reg.half_cnt + 1'b1;
    seq_next = seq_reg;
    seq_next.phase = phase_adv;
    unique case (seq_reg.state)
      BTS_IDLE: begin
        seq_next.half_cnt = '0;
        if (osc_continuous) begin
          start = 1'b1;
        end else if (burst_kind_select == BTS_KIND_GATE) begin
          start = trig_bus.gate_level;
        end else if (refused || mark_halves == '0) begin
          start = 1'b0;
        end else if (burst_kind_select == BTS_KIND_AUTO) begin
          start = 1'b1;
        end else if (burst_kind_select == BTS_KIND_TRIG) begin
          if (trig_bus.trig_now) begin
            start = 1'b1;
          end else if (trig_bus.trig_delayed) begin
            if (trigger_latency == '0) begin
              start = 1'b1;
            end else begin
              seq_next.state   = BTS_DELAY;
              seq_next.lat_cnt = trigger_latency;
            end
          end
        end
        if (burst_kind_select == BTS_KIND_TRIG && !osc_continuous &&
            !refused && mark_halves != '0 &&
            (trig_bus.trig_now || trig_bus.trig_delayed)) begin
          seq_next.seen = 1'b1;
        end else begin
          seq_next.seen = 1'b0;
        end
      end
      BTS_DELAY: begin
        // Further triggers ignored while counting down
        // Continuous mode must not sit out a pending latency
        seq_next.lat_cnt = seq_reg.lat_cnt - 1'b1;
        if (osc_continuous || seq_reg.lat_cnt <= 1) begin
          start = 1'b1;
        end
      end
      BTS_RUN: begin
        if (half_cross) begin
          seq_next.half_cnt = cnt_inc;
        end
        if (osc_continuous) begin
          seq_next.half_cnt = '0;
        end else if (burst_kind_select == BTS_KIND_GATE) begin
          // Stop at the next boundary after the gate drops
          if (!trig_bus.gate_level &&
              (stop_unit_half ? half_cross : full_cross)) begin
            seq_next.state = BTS_IDLE;
          end
        end else if (half_cross && cnt_inc >= mark_halves) begin
          // Mark finished on a start/stop boundary
          seq_next.half_cnt = '0;
          if (burst_kind_select == BTS_KIND_AUTO && !refused &&
              space_halves != '0) begin
            seq_next.state = BTS_SPACE;
          end else if (burst_kind_select == BTS_KIND_AUTO && !refused) begin
            seq_next.state = BTS_RUN;
          end else begin
            seq_next.state = BTS_IDLE;
          end
        end
      end
      BTS_SPACE: begin
        if (half_cross) begin
          seq_next.half_cnt = cnt_inc;
        end
        // Auto keeps cycling until the kind changes, noise or DC is refused, or continuous
        if (osc_continuous) begin
          start = 1'b1;
        end else if (burst_kind_select != BTS_KIND_AUTO || refused) begin
          seq_next.state = BTS_IDLE;
        end else if (half_cross && cnt_inc >= space_halves) begin
          seq_next.state    = BTS_RUN;
          seq_next.half_cnt = '0;
        end
      end
    endcase
    // Bursts open at the start/stop phase
    if (start) begin
      seq_next.state    = BTS_RUN;
      seq_next.phase    = start_phase;
      seq_next.half_cnt = '0;
      seq_next.lat_cnt  = '0;
    end
    if (seq_reg.state != BTS_IDLE) begin
      seq_next.seen = seq_reg.seen | seq_next.seen;
    end
    if (seq_next.state == BTS_IDLE) begin
      seq_next.seen = 1'b0;
    end
    seq_next.active = (seq_next.state == BTS_RUN);
    // Hold the stop-phase sample when leaving oscillation
    if (seq_reg.active && !seq_next.active) begin
      seq_next.idle_hold = wave_sample;
    end
    // Output level: live wave, held sample or override level
    if (seq_next.active) begin
      seq_next.level = wave_sample;
    end else if (idle_level_override) begin
      seq_next.level = pct_level;
    end else begin
      seq_next.level = seq_reg.active ? wave_sample : seq_reg.idle_hold;
    end
    // Sync pin source select
    if (sync_output_select == BTS_SYNC_ACTIVITY) begin
      seq_next.sync = ~seq_next.active;
    end else begin
      seq_next.sync = ~seq_next.phase[BTS_PHASE_W-1];
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seq_reg.state     <= BTS_IDLE;
      seq_reg.phase     <= BTS_PHASE_RST;
      seq_reg.half_cnt  <= '0;
      seq_reg.lat_cnt   <= '0;
      seq_reg.idle_hold <= BTS_SAMPLE_RST;
      seq_reg.level     <= BTS_SAMPLE_RST;
      seq_reg.sync      <= BTS_SYNC_RST;
      seq_reg.active    <= 1'b0;
      seq_reg.seen      <= 1'b0;
    end else begin
      seq_reg <= seq_next;
    end
  end

  // Outputs straight from the state register
  assign phase_out  = seq_reg.phase;
  assign level_out  = seq_reg.level;
  assign sync_out   = seq_reg.sync;
  assign osc_active = seq_reg.active;
  assign trig_seen  = seq_reg.seen;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_refuse_noise: assert property (@(posedge clk) disable iff (rst)
    (seq_reg.state == BTS_IDLE && refused && !osc_continuous &&
     burst_kind_select != BTS_KIND_GATE) |=> seq_reg.state == BTS_IDLE)
    else $error("burst started on noise or DC");

  a_trig_lockout: assert property (@(posedge clk) disable iff (rst)
    (seq_reg.state == BTS_RUN) |=>
      (seq_reg.state != BTS_DELAY && phase_out == $past(phase_adv)))
    else $error("trigger accepted during burst");

  a_sync_activity: assert property (@(posedge clk) disable iff (rst)
    ($past(sync_output_select) == BTS_SYNC_ACTIVITY) |->
      sync_out == !osc_active)
    else $error("activity sync not inverse of oscillation");

  a_latency_end: assert property (@(posedge clk) disable iff (rst)
    (seq_reg.state == BTS_DELAY && seq_reg.lat_cnt == 1) |=>
      (seq_reg.state == BTS_RUN && osc_active))
    else $error("latency expiry did not start burst");

  a_cont_run: assert property (@(posedge clk) disable iff (rst)
    (osc_continuous && $past(osc_continuous)) |=> osc_active)
    else $error("continuous mode not oscillating");

  a_seen_lamp: assert property (@(posedge clk) disable iff (rst)
    (seq_reg.state == BTS_IDLE && seq_next.state != BTS_IDLE &&
     burst_kind_select == BTS_KIND_TRIG && !osc_continuous) |=> trig_seen)
    else $error("trigger seen lamp not lit");

  a_idle_override: assert property (@(posedge clk) disable iff (rst)
    (!seq_next.active && idle_level_override) |=>
      level_out == $past(pct_level))
    else $error("idle override level wrong");

  a_start_phase: assert property (@(posedge clk) disable iff (rst)
    (seq_reg.state == BTS_IDLE && seq_next.state == BTS_RUN) |=>
      phase_out == $past(start_phase))
    else $error("burst did not start at start phase");

  a_manual_direct: assert property (@(posedge clk) disable iff (rst)
    (seq_reg.state == BTS_IDLE && trig_bus.trig_now && !refused &&
     burst_kind_select == BTS_KIND_TRIG && mark_halves != '0)
      |=> seq_reg.state == BTS_RUN)
    else $error("manual trigger was delayed");

  a_gate_hold: assert property (@(posedge clk) disable iff (rst)
    (seq_reg.state == BTS_RUN && burst_kind_select == BTS_KIND_GATE &&
     trig_bus.gate_level) |=> osc_active)
    else $error("gate burst stopped while gate on");

endmodule : bts_sequencer
`default_nettype wire

// File: bench/bts_far_model.sv
`timescale 1ns/100ps
`default_nettype none
module bts_far_model
  import bts_pkg::*;
(
  // Clock and request from the bench
  input  wire logic                   clk,
  input  wire logic                   fire,
  // Design side
  input  wire logic [BTS_PHASE_W-1:0] phase_out,
  input  wire logic                   sync_out,
  output logic                        ext_trig_in,
  output logic [BTS_SAMPLE_W-1:0]     wave_sample,
  output logic [15:0]                 sync_rises
);
  logic       fire_q = 1'b0;
  logic       sync_q = 1'b1;
  logic [1:0] hold   = 2'h0;
  logic       pin_q  = 1'b0;
  logic [15:0] rise_n = 16'h0000;

  // Pin and observer count each have one driver
  assign ext_trig_in = pin_q;
  assign sync_rises  = rise_n;

  // Square table; two distinct levels make the held idle level visible
  assign wave_sample = phase_out[BTS_PHASE_W-1] ? 16'h8001 : 16'h7FFF;

  // A request becomes a three cycle pulse, launched off the falling edge
  always @(posedge clk) fire_q <= fire;
  always @(negedge clk) begin
    if (fire_q)
      hold <= 2'h3;
    else if (hold != 2'h0)
      hold <= hold - 2'h1;
    pin_q <= (hold != 2'h0);
  end

  // Rises on the sync pin, sampled where the design launches them
  always @(posedge clk) begin
    sync_q <= sync_out;
    if (sync_out && !sync_q)
      rise_n <= rise_n + 16'h0001;
  end
endmodule : bts_far_model
`default_nettype wire

// File: bench/test_burst_trigger_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module test_burst_trigger_sequencer;
  import bts_pkg::*;

  // ------------------------------
  // Signals
  // ------------------------------
  logic clk = 1'b0, rst = 1'b1, osc_continuous = 1'b0;
  logic stop_unit_half = 1'b0, wave_is_noise_dc = 1'b0;
  logic idle_level_override = 1'b0, sync_output_select = 1'b1;
  logic trig_src_ext = 1'b1, chan_display_active = 1'b1;
  logic manual_trigger_key = 1'b0, remote_trig = 1'b0, ext_fire = 1'b0;
  logic [1:0] burst_kind_select = 2'h1, ext_polarity = 2'h0;
  logic [31:0] freq_word = 32'h10000000, start_phase = 32'h00000000;
  logic [15:0] mark_halves = 16'h0004, space_halves = 16'h0002;
  logic signed [7:0] idle_level_pct = 8'sh00;
  logic [23:0] int_period = 24'h000000, trigger_latency = 24'h000000;
  logic [31:0] phase_out;
  logic [15:0] wave_sample, level_out, sync_rises;
  logic ext_trig_in, sync_out, osc_active, trig_seen;
  int num_errors = 0, check_count = 0;

  // ------------------------------
  // Design and far side
  // ------------------------------
  bts_sequencer dut (.clk, .rst, .osc_continuous, .burst_kind_select,
    .freq_word, .start_phase, .mark_halves, .space_halves, .stop_unit_half,
    .wave_is_noise_dc, .idle_level_override, .idle_level_pct,
    .sync_output_select, .trig_src_ext, .ext_polarity, .int_period,
    .trigger_latency, .chan_display_active, .ext_trig_in,
    .manual_trigger_key, .remote_trig, .wave_sample, .phase_out,
    .level_out, .sync_out, .osc_active, .trig_seen);
  bts_far_model far (.clk, .fire(ext_fire), .phase_out, .sync_out,
    .ext_trig_in, .wave_sample, .sync_rises);

  // 50 ns clock
  initial begin
    forever #25 clk = ~clk;
  end

  // ------------------------------
  // Helpers
  // ------------------------------
  task automatic chk(input string what, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic close_out;
    if (num_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  // Bounded wait; a stuck design returns 400
  task automatic wait_osc(input logic lvl, output int t);
    t = 0;
    while (osc_active !== lvl && t < 400) begin
      @(negedge clk);
      t++;
    end
  endtask : wait_osc

  task automatic drain;
    int t;
    wait_osc(1'b0, t);
    repeat (4) @(negedge clk);
  endtask : drain

  task automatic pulse_remote;
    remote_trig = 1'b1;
    @(negedge clk);
    remote_trig = 1'b0;
  endtask : pulse_remote

  task automatic fire_ext(output int t);
    ext_fire = 1'b1;
    @(negedge clk);
    ext_fire = 1'b0;
    wait_osc(1'b1, t);
  endtask : fire_ext

  // ------------------------------
  // Scenarios
  // ------------------------------
  // Remote start, lockout mid-burst, length and stop phase
  task automatic t_remote;
    int t;
    pulse_remote();
    chk("osc_early", osc_active, 1'b0);
    @(negedge clk);
    chk("osc_start", osc_active, 1'b1);
    chk("trig_seen", trig_seen, 1'b1);
    chk("sync_act", sync_out, 1'b0);
    chk("phase_start", phase_out, start_phase);
    pulse_remote();
    wait_osc(1'b0, t);
    chk("mark_len", t, 32'h1F);
    chk("stop_ph", phase_out[31], start_phase[31]);
    chk("sync_idle", sync_out, 1'b1);
    chk("seen_clr", trig_seen, 1'b0);
    repeat (12) @(negedge clk);
    chk("no_retrig", osc_active, 1'b0);
  endtask : t_remote

  // External edges, latency, manual key and channel gating
  task automatic t_ext;
    int t0, t5, tf, t;
    ext_polarity = BTS_POL_RISE;
    fire_ext(t0);
    drain();
    trigger_latency = 24'h000005;
    fire_ext(t5);
    chk("ext_lat", t5 - t0, 32'h5);
    drain();
    pulse_remote();
    wait_osc(1'b1, t);
    chk("remote_lat", t, 32'h1);
    drain();
    manual_trigger_key = 1'b1;
    @(negedge clk);
    wait_osc(1'b1, t);
    chk("manual_lat", t, 32'h1);
    manual_trigger_key = 1'b0;
    drain();
    trigger_latency = 24'h000000;
    ext_polarity = BTS_POL_FALL;
    fire_ext(tf);
    chk("ext_fall", tf - t0, 32'h3);
    drain();
    ext_polarity = BTS_POL_OFF;
    fire_ext(t);
    chk("pol_off", osc_active, 1'b0);
    chan_display_active = 1'b0;
    manual_trigger_key = 1'b1;
    repeat (20) @(negedge clk);
    chk("key_other", osc_active, 1'b0);
    manual_trigger_key = 1'b0;
    chan_display_active = 1'b1;
    wave_is_noise_dc = 1'b1;
    pulse_remote();
    repeat (20) @(negedge clk);
    chk("noise_dc", osc_active, 1'b0);
    wave_is_noise_dc = 1'b0;
  endtask : t_ext

  // Internal period, then auto burst cadence and halting it
  task automatic t_periodic;
    int a, b;
    trig_src_ext = 1'b0;
    int_period = 24'h00003C;
    wait_osc(1'b1, a);
    wait_osc(1'b0, a);
    wait_osc(1'b1, b);
    chk("int_per", a + b, 32'h3C);
    int_period = 24'h000000;
    trig_src_ext = 1'b1;
    drain();
    burst_kind_select = BTS_KIND_AUTO;
    wait_osc(1'b1, a);
    wait_osc(1'b0, a);
    wait_osc(1'b1, b);
    chk("auto_per", a + b, 32'h30);
    repeat (50) begin
      @(negedge clk);
      chk("auto_sync", sync_out, !osc_active);
    end
    burst_kind_select = 2'h3;
    drain();
    repeat (60) @(negedge clk);
    chk("auto_halt", osc_active, 1'b0);
    burst_kind_select = BTS_KIND_TRIG;
  endtask : t_periodic

  // Continuous run with phase sync
  task automatic t_cont;
    logic [31:0] p;
    logic [15:0] r;
    osc_continuous = 1'b1;
    sync_output_select = BTS_SYNC_PHASE;
    repeat (2) @(negedge clk);
    p = phase_out;
    @(negedge clk);
    chk("cont_step", phase_out - p, freq_word);
    r = sync_rises;
    repeat (64) @(negedge clk);
    chk("sync_rises", sync_rises - r, 16'h0004);
    osc_continuous = 1'b0;
    sync_output_select = BTS_SYNC_ACTIVITY;
    repeat (40) @(negedge clk);
  endtask : t_cont

  // Idle level override, odd half-cycle count
  task automatic t_idle;
    int t;
    start_phase = 32'h40000000;
    mark_halves = 16'h0003;
    idle_level_override = 1'b1;
    idle_level_pct = 8'sh64;
    repeat (40) @(negedge clk);
    pulse_remote();
    @(negedge clk);
    chk("ovr_start", phase_out, start_phase);
    wait_osc(1'b0, t);
    chk("odd_stop", phase_out[31], !start_phase[31]);
    repeat (2) @(negedge clk);
    chk("lvl_full", level_out, 16'h7FFF);
    idle_level_pct = 8'sh00;
    repeat (2) @(negedge clk);
    chk("lvl_zero", level_out, 16'h0000);
    idle_level_override = 1'b0;
    repeat (2) @(negedge clk);
    chk("lvl_held", level_out, 16'h8001);
  endtask : t_idle

  // Gate held by the key; whole then half cycle stop unit
  task automatic t_gate;
    int t;
    burst_kind_select = BTS_KIND_GATE;
    for (int h = 0; h < 2; h++) begin
      stop_unit_half = h[0];
      manual_trigger_key = 1'b1;
      repeat (20) @(negedge clk);
      manual_trigger_key = 1'b0;
      wait_osc(1'b0, t);
      chk("gate_len", t, h[0] ? 32'h6 : 32'hE);
      chk("gate_ph", phase_out,
          start_phase + (h[0] ? 32'h80000000 : 32'h0));
      repeat (4) @(negedge clk);
    end
  endtask : t_gate

  // ------------------------------
  // Sequence and watchdog
  // ------------------------------
  initial begin
    repeat (6) @(negedge clk);
    chk("rst_sync", sync_out, 1'b1);
    chk("rst_osc", osc_active, 1'b0);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    t_remote();
    t_ext();
    t_periodic();
    t_cont();
    t_idle();
    t_gate();
    close_out();
  end

  // Whole run is under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    close_out();
  end
endmodule : test_burst_trigger_sequencer
`default_nettype wire
